// ===== rtl/fr_defines.vh
`ifndef FR_DEFINES_VH
`define FR_DEFINES_VH

// Register byte offsets
`define A_CTRL      8'h00
`define A_STAT      8'h04
`define A_SERR      8'h08
`define A_MRC       8'h0c
`define A_XREQ      8'h10
`define A_TERR      8'h14
`define A_TCF       8'h18
`define A_TOFF      8'h1c
`define A_GCSR      8'h20

// Control register fields
`define F_CMD_HI    3
`define F_CMD_LO    0
`define F_SLM_HI    5
`define F_SLM_LO    4
`define F_COLD_EN   8
`define F_ESM_EN    9
`define SLM_SINGLE  2'h0

// Protocol commands
`define CMD_CONFIG  4'h1
`define CMD_READY   4'h2
`define CMD_RUN     4'h3
`define CMD_HALT    4'h4
`define CMD_FREEZE  4'h5
`define CMD_DEFCFG  4'h6

// Transfer request fields
`define F_XBUF_HI   2
`define F_XBUF_LO   0
`define F_XDIR      8
`define F_PLC_HI    22
`define F_PLC_LO    16

// Error signalling target
`define ESM_GROUP   2'h1
`define ESM_CHANNEL 7'h48

// Startup listen time
`define CLK_MHZ     20
`define LISTEN_US   100
`define LISTEN_CYC  (`LISTEN_US * `CLK_MHZ)

`endif

// ===== rtl/msg_ram.v
`timescale 1ns/1ps
`default_nettype none

module msg_ram #(
    parameter AW = 10,
    parameter DW = 32
) (
    // Clock
    input  wire          clk_i,
    // Access port
    input  wire          we_i,
    input  wire          re_i,
    input  wire [AW-1:0] addr_i,
    input  wire [DW-1:0] wdata_i,
    output reg  [DW-1:0] rdata_o
);

    reg [DW-1:0] mem [0:(1<<AW)-1];

    // Read data only moves on a read, so it holds while a word waits
    always @(posedge clk_i) begin
        if (we_i) begin
            mem[addr_i] <= wdata_i;
        end
        if (re_i) begin
            rdata_o <= mem[addr_i];
        end
    end

endmodule

`default_nettype wire

// ===== rtl/skid_buf.v
`timescale 1ns/1ps
`default_nettype none

module skid_buf #(
    parameter DW = 32
) (
    // Clock and reset
    input  wire          clk_i,
    input  wire          rst_i,
    // Fill side
    input  wire          in_valid_i,
    input  wire [DW-1:0] in_data_i,
    output reg           in_ready_o,
    // Drain side
    output reg           out_valid_o,
    output reg  [DW-1:0] out_data_o,
    input  wire          out_ready_i
);

    reg [DW-1:0] skid_r;

    // Two entries: output register plus one skid word
    always @(posedge clk_i) begin
        if (rst_i) begin
            in_ready_o  <= 1'b1;
            out_valid_o <= 1'b0;
            out_data_o  <= {DW{1'b0}};
            skid_r      <= {DW{1'b0}};
        end else if (in_ready_o) begin
            if (out_valid_o && !out_ready_i) begin
                if (in_valid_i) begin
                    skid_r     <= in_data_i;
                    in_ready_o <= 1'b0;
                end
            end else begin
                out_valid_o <= in_valid_i;
                out_data_o  <= in_data_i;
            end
        end else if (out_ready_i) begin
            out_data_o <= skid_r;
            in_ready_o <= 1'b1;
        end
    end

endmodule

`default_nettype wire

// ===== rtl/fr_cc_core.v
// How it works
// - Halt entry keeps slot mode; default-config resets it
// - Slot mode writable only in config states
// - Single error sets readable flag and address
// - Error corrected; signalled to group 1 channel 72
// - Output transfer moves only the message words
// - Input transfer makes no extra trailing write
// - Data partition starts after last configured header
// - Receive moves use data pointer beside host traffic
// - Coldstart listens first, then sends collision symbol
// - Startup frame sent in cycles 0 to 3
// - Protection violation clears transfer unit enabled
// - Protection violation sets transfer error flag
// - Offset read clears matching complete flag
// - Offset shows highest recently completed buffer
// - Ready command ignored while already ready
`timescale 1ns/1ps
`default_nettype none
`include "fr_defines.vh"

module fr_cc_core #(
    parameter AW         = 10,
    parameter NBUF       = 8,
    parameter DATA_WORDS = 64,
    parameter LISTEN_CYC = `LISTEN_CYC
) (
    // Clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // Wishbone slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    // Output buffer stream
    output wire [31:0] ob_data_o,
    output wire        ob_valid_o,
    input  wire        ob_ready_i,
    // Input buffer stream
    input  wire [31:0] ib_data_i,
    input  wire        ib_valid_i,
    output reg         ib_ready_o,
    // Transient buffer moves
    input  wire        rx_valid_i,
    input  wire [2:0]  rx_buf_i,
    input  wire [5:0]  rx_idx_i,
    input  wire [31:0] rx_data_i,
    // Memory checker
    input  wire        mem_sbe_i,
    // Bus protocol
    input  wire        cycle_start_i,
    input  wire        comm_seen_i,
    output reg         cas_tx_o,
    output reg         sf_tx_o,
    output reg         esm_err_o
);

    ////////////////////////////////////////////////////////////////////
    localparam S_DEFCFG = 8'h01;
    localparam S_CFG    = 8'h02;
    localparam S_READY  = 8'h04;
    localparam S_LISTEN = 8'h08;
    localparam S_COLD   = 8'h10;
    localparam S_NACT   = 8'h20;
    localparam S_NPAS   = 8'h40;
    localparam S_HALT   = 8'h80;
    localparam X_IDLE   = 3'h1;
    localparam X_OB     = 3'h2;
    localparam X_IB     = 3'h4;

    reg  [7:0]      poc_r, poc_nxt;
    reg  [1:0]      slm_r;
    reg             cold_en_r, esm_en_r, csi_r;
    reg  [15:0]     lst_r;
    reg  [2:0]      sfc_r;
    reg  [2:0]      lcb_r;
    reg             tue_r, pv_r, sbe_r;
    reg  [AW-1:0]   sbe_adr_r, rd_adr_r;
    reg  [NBUF-1:0] tcf_r, trig_r;
    reg  [2:0]      xbuf_r;
    reg             xdir_r;
    reg  [6:0]      xn_r, xcnt_r, acnt_r;
    reg  [2:0]      xst_r;
    reg             rd_pend_r, hold_v_r;
    reg  [31:0]     hold_r;

    ////////////////////////////////////////////////////////////////////
    // Bus decode: one wait state, writes need all four byte lanes
    wire       req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire       wr   = req & wb_we_i & (wb_sel_i == 4'hf);
    wire       rd   = req & ~wb_we_i;
    wire [3:0] cmd  = wb_dat_i[`F_CMD_HI:`F_CMD_LO];
    wire       wcmd = wr && (wb_adr_i == `A_CTRL);

    // Highest set complete flag is the offset, built at read time
    reg  [2:0] toff;
    reg        toff_v;
    integer    i;
    always @* begin
        toff   = 3'h0;
        toff_v = 1'b0;
        for (i = 0; i < NBUF; i = i + 1) begin
            if (tcf_r[i]) begin
                toff   = i[2:0];
                toff_v = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Protocol operation controller
    wire listen_done = (lst_r == LISTEN_CYC[15:0]);
    always @* begin
        poc_nxt = poc_r;
        case (poc_r)
            S_DEFCFG: begin
                if (wcmd && cmd == `CMD_CONFIG) poc_nxt = S_CFG;
            end
            S_CFG: begin
                if (wcmd && cmd == `CMD_READY) poc_nxt = S_READY;
            end
            S_READY: begin
                // A repeated ready command falls through untouched
                if (wcmd && cmd == `CMD_RUN) poc_nxt = S_LISTEN;
                else if (wcmd && cmd == `CMD_CONFIG) poc_nxt = S_CFG;
            end
            S_LISTEN: begin
                if (comm_seen_i) poc_nxt = S_NPAS;
                else if (listen_done && cold_en_r)
                    poc_nxt = S_COLD;
            end
            S_COLD: begin
                if (cycle_start_i && sfc_r == 3'h3) poc_nxt = S_NACT;
            end
            S_NACT, S_NPAS: begin
                if (wcmd && cmd == `CMD_HALT) poc_nxt = S_HALT;
            end
            S_HALT: begin
                if (wcmd && cmd == `CMD_DEFCFG) poc_nxt = S_DEFCFG;
            end
            default: poc_nxt = S_DEFCFG;
        endcase
        if (wcmd && cmd == `CMD_FREEZE && poc_r != S_DEFCFG)
            poc_nxt = S_HALT;
        if (wcmd && cmd == `CMD_READY && (poc_r == S_LISTEN ||
            poc_r == S_COLD || poc_r == S_NACT || poc_r == S_NPAS))
            poc_nxt = S_READY;
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            poc_r     <= S_DEFCFG;
            slm_r     <= `SLM_SINGLE;
            cold_en_r <= 1'b0;
            esm_en_r  <= 1'b0;
            csi_r     <= 1'b0;
            lst_r     <= 16'h0000;
            sfc_r     <= 3'h0;
            cas_tx_o  <= 1'b0;
            sf_tx_o   <= 1'b0;
        end else begin
            poc_r    <= poc_nxt;
            cas_tx_o <= (poc_r == S_LISTEN) && (poc_nxt == S_COLD);
            // Each cycle start in coldstart carries a startup frame
            sf_tx_o  <= (poc_r == S_COLD) && cycle_start_i;
            if (wr && wb_adr_i == `A_CTRL) begin
                cold_en_r <= wb_dat_i[`F_COLD_EN];
                esm_en_r  <= wb_dat_i[`F_ESM_EN];
                if (poc_r == S_DEFCFG || poc_r == S_CFG)
                    slm_r <= wb_dat_i[`F_SLM_HI:`F_SLM_LO];
            end
            // Halt entry leaves the mode alone; only leaving halt resets
            if (poc_r == S_HALT && poc_nxt == S_DEFCFG)
                slm_r <= `SLM_SINGLE;
            if (poc_r != S_READY && poc_nxt == S_READY)
                csi_r <= 1'b1;
            else if (poc_nxt == S_DEFCFG)
                csi_r <= 1'b0;
            if (poc_r == S_LISTEN && !listen_done)
                lst_r <= lst_r + 16'h0001;
            else if (poc_r != S_LISTEN)
                lst_r <= 16'h0000;
            if (poc_r != S_COLD)
                sfc_r <= 3'h0;
            else if (cycle_start_i)
                sfc_r <= sfc_r + 3'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Memory layout and arbitration
    wire [AW-1:0] dbase = {{(AW-3){1'b0}}, lcb_r} + 1'b1;
    wire [AW-1:0] rx_adr = dbase + {{(AW-9){1'b0}}, rx_buf_i, rx_idx_i};
    wire [AW-1:0] x_adr  = dbase + {{(AW-9){1'b0}}, xbuf_r, 6'h00}
                         + {{(AW-7){1'b0}}, xcnt_r};
    // Receive moves own the port; host transfers slip one cycle
    wire grant = ~rx_valid_i;

    wire          sk_ready;
    wire          ob_issue = (xst_r == X_OB) && grant && !rd_pend_r
                           && (xcnt_r != xn_r);
    wire          ob_push  = rd_pend_r & sk_ready;
    wire          ib_acc   = ib_valid_i & ib_ready_o;
    wire          ib_wr    = (xst_r == X_IB) && hold_v_r && grant;
    wire          ram_we   = rx_valid_i | ib_wr;
    wire [AW-1:0] ram_adr  = rx_valid_i ? rx_adr : x_adr;
    wire [31:0]   ram_wd   = rx_valid_i ? rx_data_i : hold_r;
    wire [31:0]   ram_rd;

    msg_ram #(.AW(AW), .DW(32)) u_ram (
        .clk_i   (clk_i),
        .we_i    (ram_we),
        .re_i    (ob_issue),
        .addr_i  (ram_adr),
        .wdata_i (ram_wd),
        .rdata_o (ram_rd)
    );

    skid_buf #(.DW(32)) u_obuf (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .in_valid_i  (rd_pend_r),
        .in_data_i   (ram_rd),
        .in_ready_o  (sk_ready),
        .out_valid_o (ob_valid_o),
        .out_data_o  (ob_data_o),
        .out_ready_i (ob_ready_i)
    );

    ////////////////////////////////////////////////////////////////////
    // Transfer unit
    wire [6:0] req_plc = wb_dat_i[`F_PLC_HI:`F_PLC_LO];
    wire [2:0] req_buf = wb_dat_i[`F_XBUF_HI:`F_XBUF_LO];
    wire       x_start = (xst_r == X_IDLE) && (trig_r != {NBUF{1'b0}})
                       && tue_r;
    wire       pv_evt  = x_start && (xbuf_r > lcb_r);
    wire       x_done  = ((xst_r == X_OB) && xcnt_r == xn_r && !rd_pend_r)
                       || ((xst_r == X_IB) && xcnt_r == xn_r);
    wire [6:0] acnt_n  = acnt_r + {6'h00, ib_acc};
    wire       hold_n  = ib_acc | (hold_v_r & ~ib_wr);
    wire [2:0] xst_n   = (x_start && !pv_evt) ? (xdir_r ? X_IB : X_OB)
                       : (x_done ? X_IDLE : xst_r);
    wire [NBUF-1:0] done_m = x_done ? ({{(NBUF-1){1'b0}}, 1'b1} << xbuf_r)
                                    : {NBUF{1'b0}};
    wire [NBUF-1:0] rdc_m  = (rd && wb_adr_i == `A_TOFF && toff_v)
                           ? ({{(NBUF-1){1'b0}}, 1'b1} << toff)
                           : {NBUF{1'b0}};
    wire [NBUF-1:0] w1c_m  = (wr && wb_adr_i == `A_TCF)
                           ? wb_dat_i[NBUF-1:0] : {NBUF{1'b0}};

    always @(posedge clk_i) begin
        if (rst_i) begin
            xst_r      <= X_IDLE;
            xbuf_r     <= 3'h0;
            xdir_r     <= 1'b0;
            xn_r       <= 7'h00;
            xcnt_r     <= 7'h00;
            acnt_r     <= 7'h00;
            trig_r     <= {NBUF{1'b0}};
            tcf_r      <= {NBUF{1'b0}};
            tue_r      <= 1'b0;
            pv_r       <= 1'b0;
            rd_pend_r  <= 1'b0;
            hold_v_r   <= 1'b0;
            hold_r     <= 32'h0000_0000;
            ib_ready_o <= 1'b0;
            lcb_r      <= 3'h0;
        end else begin
            xst_r    <= xst_n;
            hold_v_r <= hold_n;
            if (ib_acc)
                hold_r <= ib_data_i;
            // Ready drops with the last word so no spare write follows
            ib_ready_o <= (xst_n == X_IB) && (acnt_n != xn_r)
                        && !hold_n;
            if (ob_issue)
                rd_pend_r <= 1'b1;
            else if (ob_push)
                rd_pend_r <= 1'b0;
            if (ob_issue || ib_wr)
                xcnt_r <= xcnt_r + 7'h01;
            acnt_r <= (xst_r == X_IB) ? acnt_n : 7'h00;
            if (x_start)
                xcnt_r <= 7'h00;
            // One request at a time; a request while busy is dropped
            if (wr && wb_adr_i == `A_XREQ && xst_r == X_IDLE
                && trig_r == {NBUF{1'b0}}) begin
                xbuf_r <= req_buf;
                xdir_r <= wb_dat_i[`F_XDIR];
                // Round up without a 7-bit carry: code 127 gives 64 words
                xn_r   <= {1'b0, req_plc[6:1]} + {6'h00, req_plc[0]};
                trig_r <= {{(NBUF-1){1'b0}}, 1'b1} << req_buf;
            end else if (x_start) begin
                trig_r <= {NBUF{1'b0}};
            end
            // Reads clear apart from the new done flags, so those are never masked
            tcf_r <= (tcf_r & ~rdc_m & ~w1c_m) | done_m;
            if (wr && wb_adr_i == `A_GCSR && wb_dat_i[0])
                tue_r <= 1'b1;
            if (wr && wb_adr_i == `A_GCSR && wb_dat_i[1])
                tue_r <= 1'b0;
            if (pv_evt)
                tue_r <= 1'b0;
            if (pv_evt)
                pv_r <= 1'b1;
            else if (wr && wb_adr_i == `A_TERR && wb_dat_i[0])
                pv_r <= 1'b0;
            if (wr && wb_adr_i == `A_MRC &&
                (poc_r == S_DEFCFG || poc_r == S_CFG))
                lcb_r <= wb_dat_i[2:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Single error capture; the checker has already corrected the word
    always @(posedge clk_i) begin
        if (rst_i) begin
            sbe_r     <= 1'b0;
            sbe_adr_r <= {AW{1'b0}};
            rd_adr_r  <= {AW{1'b0}};
            esm_err_o <= 1'b0;
        end else begin
            if (ob_issue)
                rd_adr_r <= ram_adr;
            if (mem_sbe_i) begin
                sbe_r     <= 1'b1;
                sbe_adr_r <= rd_adr_r;
            end else if (wr && wb_adr_i == `A_SERR && wb_dat_i[0]) begin
                sbe_r <= 1'b0;
            end
            esm_err_o <= mem_sbe_i & esm_en_r;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Register read and acknowledge
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req;
            if (rd) begin
                case (wb_adr_i)
                    `A_CTRL: wb_dat_o <= {22'h0, esm_en_r, cold_en_r,
                                          2'h0, slm_r, 4'h0};
                    `A_STAT: wb_dat_o <= {15'h0, csi_r, 5'h0, xst_r,
                                          poc_r};
                    `A_SERR: wb_dat_o <= {{(16-AW){1'b0}}, sbe_adr_r,
                                          esm_en_r ? `ESM_GROUP : 2'h0,
                                          `ESM_CHANNEL, 6'h0, sbe_r};
                    `A_MRC:  wb_dat_o <= {29'h0, lcb_r};
                    `A_XREQ: wb_dat_o <= {24'h0, trig_r};
                    `A_TERR: wb_dat_o <= {31'h0, pv_r};
                    `A_TCF:  wb_dat_o <= {24'h0, tcf_r};
                    `A_TOFF: wb_dat_o <= {23'h0, toff_v, 5'h0, toff};
                    `A_GCSR: wb_dat_o <= {31'h0, tue_r};
                    default: wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule

`default_nettype wire

// ===== verification/fr_cc_core_sva.sv
`timescale 1ns/1ps
`default_nettype none
module fr_cc_core_sva (
    // Clock and reset
    input wire logic        clk_i,
    input wire logic        rst_i,
    // Watched ports
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o,
    input wire logic [31:0] ob_data_o,
    input wire logic        ob_valid_o,
    input wire logic        ob_ready_i,
    input wire logic        ib_valid_i,
    input wire logic        ib_ready_o,
    input wire logic        mem_sbe_i,
    input wire logic        cycle_start_i,
    input wire logic        cas_tx_o,
    input wire logic        sf_tx_o,
    input wire logic        esm_err_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [2:0] sf_cnt_r;
    ////////////////////////////////////////////////////////////////////////
    // Saturates so a runaway sender cannot wrap back under the limit
    always_ff @(posedge clk_i) begin
        if (rst_i || cas_tx_o) sf_cnt_r <= 3'h0;
        else if (sf_tx_o && sf_cnt_r != 3'h7) sf_cnt_r <= sf_cnt_r + 3'h1;
    end
    ////////////////////////////////////////////////////////////////////////
    ack_reply_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
        |=> wb_ack_o) else $error("request not acknowledged");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    sf_cause_a: assert property (sf_tx_o |-> $past(cycle_start_i))
        else $error("startup frame outside cycle start");
    sf_count_a: assert property (sf_cnt_r <= 3'h4)
        else $error("more than four startup frames");
    cas_single_a: assert property (cas_tx_o |=> !cas_tx_o)
        else $error("collision symbol repeated");
    esm_cause_a: assert property (esm_err_o
        |-> $past(mem_sbe_i) || $past(mem_sbe_i, 2))
        else $error("error signal without single error");
    ob_hold_a: assert property (ob_valid_o && !ob_ready_i
        |=> ob_valid_o && $stable(ob_data_o)) else $error("word lost");
    ib_space_a: assert property (ib_valid_i && ib_ready_o
        |=> !ib_ready_o) else $error("input word too soon");
    reset_quiet_a: assert property (disable iff (1'b0) rst_i
        |=> !wb_ack_o && !ob_valid_o && !ib_ready_o && !cas_tx_o)
        else $error("outputs active in reset");
endmodule

bind fr_cc_core fr_cc_core_sva sva_u (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .ob_data_o,
    .ob_valid_o, .ob_ready_i, .ib_valid_i, .ib_ready_o, .mem_sbe_i,
    .cycle_start_i, .cas_tx_o, .sf_tx_o, .esm_err_o
);
`default_nettype wire

// ===== verification/bus_nodes.sv
`timescale 1ns/1ps
`default_nettype none
module bus_nodes #(
    parameter int PERIOD = 16
) (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Bus events
    output logic      cycle_start_o,
    output logic      comm_seen_o
);
    logic [7:0] cnt_r;
    ////////////////////////////////////////////////////////////////////////
    // Cycle long enough for a startup frame in slot 8 or later
    always_ff @(posedge clk_i) begin
        if (rst_i || cnt_r == 8'(PERIOD - 1)) cnt_r <= 8'h0;
        else cnt_r <= cnt_r + 8'h1;
    end
    assign cycle_start_o = (cnt_r == 8'h0) && !rst_i;
    // Other nodes stay silent, so this node must lead the coldstart
    assign comm_seen_o = 1'b0;
endmodule
`default_nettype wire

// ===== verification/fr_cc_core_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "fr_defines.vh"
module fr_cc_core_test;
    localparam int LST = 8;
    logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0;
    logic        we = 1'b0, ob_ready = 1'b0, ib_valid = 1'b0, single_error_flag = 1'b0;
    logic        rx_valid = 1'b0, ack, ob_valid, ib_ready, cstart, comm;
    logic        cas, sf, error_signal_module;
    logic [7:0]  adr = 8'h00;
    logic [2:0]  rx_buf = 3'h3;
    logic [5:0]  rx_idx = 6'h00;
    logic [31:0] wdat = 32'h0, ib_data = 32'h0, rx_data = 32'h0;
    logic [31:0] rdat, ob_data, q, ctl = 32'h320;
    logic [71:0] rows [7];
    int          errors = 0, num_checks = 0, cas_n = 0, sf_n = 0, esm_n = 0;

    fr_cc_core #(.LISTEN_CYC(LST)) dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .ob_data_o(ob_data),
        .ob_valid_o(ob_valid), .ob_ready_i(ob_ready), .ib_data_i(ib_data),
        .ib_valid_i(ib_valid), .ib_ready_o(ib_ready), .rx_valid_i(rx_valid),
        .rx_buf_i(rx_buf), .rx_idx_i(rx_idx), .rx_data_i(rx_data),
        .mem_sbe_i(single_error_flag), .cycle_start_i(cstart), .comm_seen_i(comm),
        .cas_tx_o(cas), .sf_tx_o(sf), .esm_err_o(error_signal_module));
    bus_nodes nodes_u (.clk_i(clk_i), .rst_i(rst_i), .cycle_start_o(cstart),
        .comm_seen_o(comm));
    ////////////////////////////////////////////////////////////////////////
    initial forever #25 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        if (cas === 1'b1) cas_n <= cas_n + 1;
        if (sf === 1'b1) sf_n <= sf_n + 1;
        if (error_signal_module === 1'b1) esm_n <= esm_n + 1;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        if (errors == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic hang();
        $display("CHECK FAILED t=%0t wait timed out", $time);
        errors++;
        print_verdict();
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Request held until the edge that samples ack, then released
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) hang();
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, e);
        wb(1'b0, a, 32'h0);
        chk(q & m, e);
    endtask
    task automatic cmd(input logic [3:0] c);
        wr(`A_CTRL, ctl | {28'h0, c});
    endtask
    task automatic xreq(input logic [2:0] b, input logic d, logic [6:0] p);
        wr(`A_XREQ, {9'h0, p, 7'h0, d, 5'h0, b});
    endtask
    task automatic push(input int n, input logic [31:0] base);
        int k, t;
        k = 0;
        t = 0;
        @(posedge clk_i);
        ib_valid <= 1'b1;
        ib_data <= base;
        while (k < n && t < 500) begin
            @(posedge clk_i);
            t++;
            if (ib_ready === 1'b1) begin
                k++;
                ib_data <= base + 32'(k);
                if (k == n) ib_valid <= 1'b0;
            end
        end
        if (t >= 500) hang();
    endtask
    // Fixed window so a surplus word after the last one is caught too
    task automatic pull(input int n, input logic [31:0] base);
        int k;
        k = 0;
        for (int t = 1; t < 600; t++) begin
            @(posedge clk_i);
            if (ob_valid === 1'b1 && ob_ready === 1'b1) begin
                chk(ob_data, base + 32'(k));
                k++;
            end
            ob_ready <= (t > 6) && (t % 3 != 0);
        end
        chk(32'(k), 32'(n));
    endtask
    task automatic wait_tcf(input logic [31:0] m);
        int n;
        n = 0;
        do begin
            wb(1'b0, `A_TCF, 32'h0);
            n++;
        end while ((q & m) == 32'h0 && n < 40);
        if (n >= 40) hang();
    endtask
    task automatic start();
        int t, c0, s0;
        c0 = cas_n;
        s0 = sf_n;
        t = 0;
        cmd(`CMD_RUN);
        while (cas_n == c0 && t < 200) begin
            @(posedge clk_i);
            t++;
        end
        chk(32'(t >= LST / 2), 32'h1);
        while (sf_n < s0 + 4 && t < 400) begin
            @(posedge clk_i);
            t++;
        end
        if (t >= 400) hang();
        chk(32'(cas_n - c0), 32'h1);
        rd(`A_STAT, 32'hff, 32'h20);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        rows = '{{`A_STAT, 32'hff, 32'h1}, {`A_CTRL, 32'h30, 32'h0},
            {`A_GCSR, 32'h1, 32'h0}, {`A_TERR, 32'h1, 32'h0},
            {`A_TCF, 32'hff, 32'h0}, {`A_SERR, 32'h1, 32'h0},
            {8'h24, 32'hffffffff, 32'h0}};
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (rows[i]) rd(rows[i][71:64], rows[i][63:32], rows[i][31:0]);
        wr(`A_CTRL, ctl);
        rd(`A_CTRL, 32'h30, 32'h20);
        // Later passes stop with a freeze, the last restarts after ready too
        for (int i = 0; i < 3; i++) begin
            cmd(`CMD_CONFIG);
            wr(`A_MRC, 32'h3);
            cmd(`CMD_READY);
            cmd(`CMD_READY);
            rd(`A_STAT, 32'hff, 32'h04);
            wr(`A_CTRL, 32'h310);
            rd(`A_CTRL, 32'h30, 32'h20);
            start();
            if (i == 2) begin
                cmd(`CMD_READY);
                start();
            end
            cmd(i == 0 ? `CMD_HALT : `CMD_FREEZE);
            rd(`A_STAT, 32'hff, 32'h80);
            rd(`A_CTRL, 32'h30, 32'h20);
            cmd(`CMD_DEFCFG);
            rd(`A_STAT, 32'hff, 32'h01);
            rd(`A_CTRL, 32'h30, 32'h00);
            wr(`A_CTRL, ctl);
        end
        cmd(`CMD_CONFIG);
        wr(`A_GCSR, 32'h1);
        rd(`A_GCSR, 32'h1, 32'h1);
        xreq(3'h2, 1'b1, 7'h01);
        push(1, 32'ha0);
        wait_tcf(32'h4);
        xreq(3'h1, 1'b1, 7'h7f);
        push(64, 32'h100);
        wait_tcf(32'h2);
        rd(`A_TCF, 32'hff, 32'h06);
        rd(`A_TOFF, 32'h107, 32'h102);
        rd(`A_TCF, 32'hff, 32'h02);
        rd(`A_TOFF, 32'h107, 32'h101);
        rd(`A_TCF, 32'hff, 32'h00);
        xreq(3'h2, 1'b0, 7'h01);
        pull(1, 32'ha0);
        xreq(3'h1, 1'b0, 7'h7f);
        fork
            pull(64, 32'h100);
            begin
                repeat (20) @(posedge clk_i);
                for (int k = 0; k < 2; k++) begin
                    @(posedge clk_i);
                    rx_valid <= 1'b1;
                    rx_idx <= 6'(k);
                    rx_data <= 32'hc0 + 32'(k);
                end
                @(posedge clk_i);
                rx_valid <= 1'b0;
            end
        join
        xreq(3'h3, 1'b0, 7'h03);
        pull(2, 32'hc0);
        wr(`A_TCF, 32'h8);
        rd(`A_TOFF, 32'h107, 32'h102);
        for (int i = 0; i < 2; i++) begin
            wr(`A_GCSR, 32'h1);
            xreq(3'h5, i[0], 7'h01);
            rd(`A_TERR, 32'h1, 32'h1);
            rd(`A_GCSR, 32'h1, 32'h0);
            wr(`A_GCSR, 32'h2);
            wr(`A_TERR, 32'h1);
        end
        @(posedge clk_i);
        single_error_flag <= 1'b1;
        @(posedge clk_i);
        single_error_flag <= 1'b0;
        rd(`A_SERR, 32'h3ffffff, 32'hc56401);
        chk(32'(esm_n), 32'h1);
        wr(`A_SERR, 32'h1);
        rd(`A_SERR, 32'h1, 32'h0);
        print_verdict();
    end
endmodule
`default_nettype wire
